// *** hw/lock_hunt.sv ***
// lock detection sequencer: rate hunting and locked flag
`timescale 1ns/1ns
`default_nettype none
`include "sdi_front_params.svh"
module lock_hunt (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic carrier_ok_i,
  input wire logic master_i,
  input wire logic rate_pin_i,
  input wire logic pll_lock_i,
  input wire logic sync_found_i,
  output logic rate_sd_o,
  output logic locked_o,
  output sdi_front_pkg::hunt_t state_o,
  output logic [2:0] tries_o
);
  import sdi_front_pkg::*;

  localparam logic [9:0] ATT_LAST = 10'(`ATTEMPT_CYC - 1);
  localparam logic [2:0] TRY_LAST = 3'(`HUNT_TRIES - 1);

  hunt_t state_ff, nxt_state;
  logic [9:0] cnt_ff, nxt_cnt;
  logic [2:0] tries_ff, nxt_tries;
  logic rate_ff, nxt_rate;
  wire good = pll_lock_i && sync_found_i;
  wire att_end = (cnt_ff == ATT_LAST);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = 10'h000;
    nxt_tries = tries_ff;
    nxt_rate = rate_ff;
    unique case (state_ff)
      H_WAIT: begin
        nxt_tries = 3'h0;
        if (carrier_ok_i) nxt_state = H_HUNT;
      end
      H_HUNT: begin
        if (!carrier_ok_i) nxt_state = H_WAIT;
        else if (good) nxt_state = H_LOCK;
        else if (!att_end) nxt_cnt = cnt_ff + 10'h001;
        else if (master_i) begin
          nxt_rate = ~rate_ff;
          nxt_tries = tries_ff + 3'h1;
          if (tries_ff == TRY_LAST) nxt_state = H_PLL;
        end
      end
      H_LOCK: begin
        if (!carrier_ok_i) nxt_state = H_WAIT;
        else if (!good) nxt_state = H_HUNT;
      end
      H_PLL: begin
        if (!carrier_ok_i) nxt_state = H_WAIT;
        else if (good) nxt_state = H_LOCK;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= H_WAIT;
      cnt_ff <= 10'h000;
      tries_ff <= 3'h0;
      rate_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      tries_ff <= nxt_tries;
      rate_ff <= nxt_rate;
    end
  end

  assign rate_sd_o = master_i ? rate_ff : rate_pin_i;
  assign locked_o = (state_ff == H_LOCK);
  assign state_o = state_ff;
  assign tries_o = tries_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_rate_toggle: assert property (
    master_i && state_ff == H_HUNT && carrier_ok_i && !good && att_end
    |=> rate_ff != $past(rate_ff))
    else $error("master hunt did not toggle rate");
  a_rate_hold: assert property (
    !master_i && $past(!master_i) |-> rate_ff == $past(rate_ff))
    else $error("rate toggled in slave role");
  a_pll_mode: assert property (
    state_ff == H_HUNT && master_i && carrier_ok_i && !good && att_end && tries_ff == TRY_LAST
    |=> state_ff == H_PLL)
    else $error("pll mode not entered after last attempt");
endmodule : lock_hunt
`default_nettype wire

// *** hw/sdi_front_ctrl.sv ***
// input select, lock, bypass and loop-through control of the serial receiver
`timescale 1ns/1ns
`default_nettype none
`include "sdi_front_params.svh"
module sdi_front_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic input_channel_select_i,
  input wire logic serial_in_ch1_i,
  input wire logic serial_in_ch2_i,
  input wire logic carrier_valid_n_ch1_i,
  input wire logic carrier_valid_n_ch2_i,
  input wire logic master_role_i,
  input wire logic pll_lock_i,
  input wire logic sync_found_i,
  input wire logic rate_select_i,
  output logic rate_select_o,
  output logic rate_select_oe_o,
  input wire logic reclock_bypass_n_i,
  output logic reclock_bypass_n_o,
  output logic reclock_bypass_n_oe_o,
  input wire logic loop_output_enable_i,
  output logic loop_serial_out_o,
  output logic loop_serial_out_n_o,
  output logic loop_serial_out_oe_o,
  output logic locked_o,
  output logic carrier_valid_o,
  output logic edc_enable_o,
  output logic corr_enable_o,
  output logic std_detect_enable_o
);
  import sdi_front_pkg::*;

  hunt_t hunt_state;
  logic [2:0] hunt_tries;
  logic rate_sd;
  logic locked;
  logic [3:0] ctrl;
  logic [31:0] status;

  logic buf_ff;
  logic rck1_ff;
  logic rck_ff;
  logic out_ff;
  logic out_n_ff;
  logic muted_ff;

  // one select drives both muxes so data and carrier never split
  wire sel_ch1 = input_channel_select_i;
  wire sel_data = sel_ch1 ? serial_in_ch1_i : serial_in_ch2_i;
  wire sel_cd_n = sel_ch1 ? carrier_valid_n_ch1_i : carrier_valid_n_ch2_i;
  wire carrier_ok = !sel_cd_n;

  // bypass source: pin in slave, own lock state in master
  wire use_reclocked = master_role_i ? locked : reclock_bypass_n_i;
  wire lock_mute = !master_role_i && reclock_bypass_n_i && !locked;
  wire mute = !carrier_ok || lock_mute || ctrl[`CTRL_MUTE_BIT];
  wire out_bit = use_reclocked ? rck_ff : buf_ff;

  lock_hunt u_hunt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .carrier_ok_i(carrier_ok),
    .master_i(master_role_i),
    .rate_pin_i(rate_select_i),
    .pll_lock_i(pll_lock_i),
    .sync_found_i(sync_found_i),
    .rate_sd_o(rate_sd),
    .locked_o(locked),
    .state_o(hunt_state),
    .tries_o(hunt_tries)
  );

  assign status = {17'h0_0000, hunt_tries, 2'b00, hunt_state, 2'b00, muted_ff,
                   use_reclocked, master_role_i, rate_sd, carrier_ok, locked};

  wb_front_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .status_i(status),
    .ctrl_o(ctrl)
  );

  // two-stage retime stands in for the reclocked path, one stage for buffered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_ff <= 1'b0;
      rck1_ff <= 1'b0;
      rck_ff <= 1'b0;
    end else begin
      buf_ff <= sel_data;
      rck1_ff <= sel_data;
      rck_ff <= rck1_ff;
    end
  end

  // muted line holds both legs low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_ff <= 1'b0;
      out_n_ff <= 1'b0;
      muted_ff <= 1'b1;
    end else begin
      out_ff <= mute ? 1'b0 : out_bit;
      out_n_ff <= mute ? 1'b0 : ~out_bit;
      muted_ff <= mute;
    end
  end

  assign loop_serial_out_o = out_ff;
  assign loop_serial_out_n_o = out_n_ff;
  assign loop_serial_out_oe_o = loop_output_enable_i;

  // role pins: outputs only in master role
  assign rate_select_o = rate_sd;
  assign rate_select_oe_o = master_role_i;
  assign reclock_bypass_n_o = locked;
  assign reclock_bypass_n_oe_o = master_role_i;

  assign locked_o = locked;
  assign carrier_valid_o = carrier_ok;
  assign edc_enable_o = ctrl[`CTRL_EDC_BIT];
  assign corr_enable_o = ctrl[`CTRL_CORR_BIT];
  assign std_detect_enable_o = ctrl[`CTRL_STD_BIT];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_mux_data_ch: assert property (
    !$past(rst_i)
    |-> buf_ff == $past(input_channel_select_i ? serial_in_ch1_i : serial_in_ch2_i))
    else $error("buffered data not from selected input");

  a_carrier_mux: assert property (
    carrier_valid_o == !(input_channel_select_i ? carrier_valid_n_ch1_i
                                                : carrier_valid_n_ch2_i))
    else $error("carrier valid not from selected detect");

  a_carrier_low_ok: assert property (
    carrier_valid_n_ch1_i && carrier_valid_n_ch2_i |-> !carrier_valid_o)
    else $error("carrier valid with both detects high");

  a_output_enable: assert property (
    loop_serial_out_oe_o == loop_output_enable_i)
    else $error("loop output enable mismatch");

  a_bypass_drive: assert property (
    master_role_i |-> reclock_bypass_n_oe_o && (reclock_bypass_n_o == locked_o))
    else $error("master bypass pin not tied to locked");

  a_slave_release: assert property (
    !master_role_i |-> !reclock_bypass_n_oe_o && !rate_select_oe_o
                       && rate_select_o == rate_select_i)
    else $error("slave role drives a control pin");

  a_mute_carrier: assert property (
    !carrier_valid_o |=> !loop_serial_out_o && !loop_serial_out_n_o)
    else $error("loop output not muted on invalid carrier");

  a_mute_unlock: assert property (
    !master_role_i && reclock_bypass_n_i && !locked_o
    |=> !loop_serial_out_o && !loop_serial_out_n_o)
    else $error("slave reclocked output not muted while unlocked");

  a_locked_cause: assert property (
    $rose(locked_o) |-> $past(pll_lock_i) && $past(sync_found_i) && $past(carrier_valid_o))
    else $error("locked raised without lock and sync");

  a_reclocked_path: assert property (
    carrier_valid_o && !ctrl[`CTRL_MUTE_BIT] && !master_role_i && reclock_bypass_n_i
    && locked_o |=> loop_serial_out_o == $past(rck_ff))
    else $error("reclocked path not selected");

  a_buffered_path: assert property (
    carrier_valid_o && !ctrl[`CTRL_MUTE_BIT] && !master_role_i && !reclock_bypass_n_i
    |=> loop_serial_out_o == $past(buf_ff))
    else $error("buffered path not selected");

  a_switch_together: assert property (
    $changed(input_channel_select_i) |=> buf_ff == $past(sel_data)
                                         && carrier_valid_o == !sel_cd_n)
    else $error("data and carrier switched apart");

  a_enables_reset: assert property (
    $fell(rst_i) |-> edc_enable_o && corr_enable_o && std_detect_enable_o)
    else $error("processing not enabled after reset");

  a_force_mute: assert property (
    ctrl[`CTRL_MUTE_BIT] |=> !loop_serial_out_o && !loop_serial_out_n_o)
    else $error("loop output not muted by control bit");

  a_out_pair: assert property (
    !muted_ff |-> loop_serial_out_n_o == !loop_serial_out_o)
    else $error("loop output legs not complementary");

  a_master_buffered: assert property (
    master_role_i && carrier_valid_o && !locked_o && !ctrl[`CTRL_MUTE_BIT]
    |=> loop_serial_out_o == $past(buf_ff))
    else $error("master unlocked output not buffered");

  c_master_lock: cover property (master_role_i && $rose(locked_o));
  c_master_pll: cover property (master_role_i && hunt_state == H_PLL);
  c_slave_buffered: cover property (!master_role_i && !reclock_bypass_n_i && carrier_valid_o);
  c_channel_swap: cover property ($changed(input_channel_select_i) && carrier_valid_o);
endmodule : sdi_front_ctrl
`default_nettype wire

// *** hw/sdi_front_params.svh ***
// timing counts, register offsets and field positions of the front-end control
`ifndef SDI_FRONT_PARAMS_SVH
`define SDI_FRONT_PARAMS_SVH

`define CLK_MHZ 25
`define ATTEMPT_US 20
`define ATTEMPT_CYC (`ATTEMPT_US * `CLK_MHZ)
`define HUNT_TRIES 4

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04

`define CTRL_EDC_BIT 0
`define CTRL_CORR_BIT 1
`define CTRL_STD_BIT 2
`define CTRL_MUTE_BIT 3
`define CTRL_RESET 4'h7

`define ST_LOCKED_BIT 0
`define ST_CARRIER_BIT 1
`define ST_RATE_SD_BIT 2
`define ST_MASTER_BIT 3
`define ST_RECLK_BIT 4
`define ST_MUTED_BIT 5
`define ST_HUNT_LSB 8
`define ST_TRIES_LSB 12

`endif

// *** hw/sdi_front_pkg.sv ***
// types shared by the front-end control modules
package sdi_front_pkg;
  typedef enum logic [1:0] {
    H_WAIT = 2'b00,
    H_HUNT = 2'b01,
    H_LOCK = 2'b10,
    H_PLL = 2'b11
  } hunt_t;
endpackage : sdi_front_pkg

// *** hw/wb_front_regs.sv ***
// classic wishbone slave: control and status words
`timescale 1ns/1ns
`default_nettype none
`include "sdi_front_params.svh"
module wb_front_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] status_i,
  output logic [3:0] ctrl_o
);
  import sdi_front_pkg::*;

  logic ack_ff;
  logic [31:0] dat_ff;
  logic [3:0] ctrl_ff;
  wire req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire hit_ctrl = (wb_adr_i == `REG_CTRL);
  wire hit_stat = (wb_adr_i == `REG_STATUS);
  // write lands at the edge where the master samples ack high
  wire wr_ctrl = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && hit_ctrl && wb_sel_i[0];
  wire [31:0] rd_mux = hit_ctrl ? {28'h000_0000, ctrl_ff} :
                       hit_stat ? status_i : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      ctrl_ff <= `CTRL_RESET;
    end else begin
      ack_ff <= req;
      if (req) dat_ff <= rd_mux;
      if (wr_ctrl) ctrl_ff <= wb_dat_i[3:0];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign ctrl_o = ctrl_ff;
endmodule : wb_front_regs
`default_nettype wire

// *** verif/eq_app_model.sv ***
// equalizer and application-layer model: serial streams and carrier detects
`timescale 1ns/1ns
`default_nettype none
module eq_app_model (
  input wire logic ok1_i,
  input wire logic ok2_i,
  input wire logic single_i,
  output logic ser1_o,
  output logic ser2_o,
  output logic cd1_n_o,
  output logic cd2_n_o
);
  // steady levels tell the two channels apart at the loop output
  assign ser1_o = 1'b1;
  assign ser2_o = single_i;
  assign cd1_n_o = ~ok1_i;
  assign cd2_n_o = single_i | ~ok2_i;
endmodule : eq_app_model
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench of the serial front-end control
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, rd;
  logic ack, sel = 1'b1, master = 1'b0, pll = 1'b0, sync = 1'b0;
  logic ok1 = 1'b0, ok2 = 1'b0, single = 1'b0, rate_drv = 1'b1, byp_drv = 1'b0, en = 1'b1;
  logic ser1, ser2, cd1_n, cd2_n, rate_o, rate_oe, byp_o, byp_oe, rate_pin, byp_pin;
  logic out, out_n, out_oe, locked, cv, edc, corr, stdd;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // two-way pins: design drives while its enable is high
  assign rate_pin = rate_oe ? rate_o : rate_drv;
  assign byp_pin = byp_oe ? byp_o : byp_drv;
  eq_app_model eq_app_model_inst (.ok1_i(ok1), .ok2_i(ok2), .single_i(single),
    .ser1_o(ser1), .ser2_o(ser2), .cd1_n_o(cd1_n), .cd2_n_o(cd2_n));
  sdi_front_ctrl sdi_front_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .input_channel_select_i(sel), .serial_in_ch1_i(ser1),
    .serial_in_ch2_i(ser2), .carrier_valid_n_ch1_i(cd1_n), .carrier_valid_n_ch2_i(cd2_n),
    .master_role_i(master), .pll_lock_i(pll), .sync_found_i(sync),
    .rate_select_i(rate_pin), .rate_select_o(rate_o), .rate_select_oe_o(rate_oe),
    .reclock_bypass_n_i(byp_pin), .reclock_bypass_n_o(byp_o),
    .reclock_bypass_n_oe_o(byp_oe), .loop_output_enable_i(en), .loop_serial_out_o(out),
    .loop_serial_out_n_o(out_n), .loop_serial_out_oe_o(out_oe), .locked_o(locked),
    .carrier_valid_o(cv), .edc_enable_o(edc), .corr_enable_o(corr),
    .std_detect_enable_o(stdd));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer
  task automatic t_regs();
    settle(1);
    chk("enables", 32'h0000_0007, {edc, corr, stdd});
    wb_xfer(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl", 32'h0000_0007, rd);
    wb_xfer(1'b1, 8'h00, 32'h0000_0006);
    settle(1);
    chk("edc off", 32'h0000_0003, {edc, corr, stdd});
    wb_xfer(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    wb_xfer(1'b1, 8'h00, 32'h0000_0007);
    $display("test regs done");
  endtask : t_regs
  task automatic t_select();
    @(posedge clk_i);
    ok1 <= 1'b1;
    ok2 <= 1'b1;
    settle(4);
    chk("ch1", 32'h0000_000C, {cv, out, out_n, ~out_oe});
    wb_xfer(1'b1, 8'h00, 32'h0000_000F);
    settle(1);
    chk("force mute", 32'h0000_0000, {out, out_n});
    wb_xfer(1'b1, 8'h00, 32'h0000_0007);
    @(posedge clk_i);
    sel <= 1'b0;
    settle(4);
    chk("ch2", 32'h0000_0005, {cv, out, out_n});
    @(posedge clk_i);
    ok2 <= 1'b0;
    settle(3);
    chk("mute", 32'h0000_0000, {cv, out, out_n});
    @(posedge clk_i);
    ok2 <= 1'b1;
    single <= 1'b1;
    en <= 1'b0;
    settle(1);
    chk("single", 32'h0000_0000, {cv, out_oe});
    @(posedge clk_i);
    single <= 1'b0;
    en <= 1'b1;
    sel <= 1'b1;
    $display("test select done");
  endtask : t_select
  task automatic t_slave();
    @(posedge clk_i);
    byp_drv <= 1'b1;
    rate_drv <= 1'b0;
    pll <= 1'b1;
    settle(4);
    chk("unlocked", 32'h0000_0000, {locked, out, out_n, rate_o, rate_oe, byp_oe});
    @(posedge clk_i);
    rate_drv <= 1'b1;
    sync <= 1'b1;
    settle(4);
    chk("rate", 32'h0000_0001, {rate_oe, rate_o});
    chk("locked", 32'h0000_0006, {locked, out, out_n});
    @(posedge clk_i);
    pll <= 1'b0;
    sync <= 1'b0;
    byp_drv <= 1'b0;
    settle(4);
    chk("buffered", 32'h0000_0002, {locked, out, out_n});
    $display("test slave done");
  endtask : t_slave
  task automatic t_master();
    @(posedge clk_i);
    ok1 <= 1'b0;
    master <= 1'b1;
    settle(3);
    @(posedge clk_i);
    ok1 <= 1'b1;
    settle(250);
    chk("hunt sd", 32'h0000_0003, {rate_oe, rate_pin});
    settle(500);
    chk("hunt hd", 32'h0000_0002, {rate_oe, rate_pin});
    chk("master buf", 32'h0000_000A, {byp_oe, byp_pin, out, out_n});
    @(posedge clk_i);
    pll <= 1'b1;
    sync <= 1'b1;
    settle(4);
    chk("master lock", 32'h0000_000E, {locked, byp_pin, out, out_n});
    wb_xfer(1'b0, 8'h04, 32'h0000_0000);
    chk("status lock", 32'h0000_121B, rd);
    @(posedge clk_i);
    pll <= 1'b0;
    sync <= 1'b0;
    settle(1600);
    chk("pll mode", 32'h0000_0002, {locked, byp_pin, out, out_n});
    wb_xfer(1'b0, 8'h04, 32'h0000_0000);
    chk("status pll", 32'h0000_430E, rd);
    $display("test master done");
  endtask : t_master
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_select();
    t_slave();
    t_master();
    stop_test();
  end
endmodule : tb
`default_nettype wire
